// *** include/mic_regs.svh ***
`ifndef MIC_REGS_SVH
`define MIC_REGS_SVH

// ----------------------------------------------------------------------
// Register byte offsets (AXI4-Lite)
// ----------------------------------------------------------------------
`define MIC_OFF_IEN_FIRST  8'ha8
`define MIC_OFF_TRIG       8'hb0
`define MIC_OFF_PRIO       8'hb4
`define MIC_OFF_IEN_SECOND 8'hb8
`define MIC_OFF_FLAGS      8'hbc
`define MIC_OFF_MASK       8'hc0
`define MIC_OFF_SVC        8'hc4

// ----------------------------------------------------------------------
// Field positions and writable masks
// ----------------------------------------------------------------------
`define MIC_IEN_GLOBAL_BIT 7
`define MIC_IEN_FIRST_WMASK  8'hdf
`define MIC_IEN_SECOND_WMASK 8'h7e
`define MIC_IEN_SECOND_LSB 1
`define MIC_TRIG_IT0_BIT   0
`define MIC_TRIG_IT1_BIT   1
`define MIC_TRIG_X2_BIT    2
`define MIC_TRIG_X3_BIT    3

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define MIC_RST_IEN  8'h00
`define MIC_RST_TRIG 4'h0
`define MIC_RST_PRIO 20'h00000
`define MIC_RST_MASK 10'h000

// ----------------------------------------------------------------------
// Timing and vectors
// ----------------------------------------------------------------------
`define MIC_LONG_CALL_MCYCLES 3'd6
`define MIC_VECTOR_BASE   16'h0003
`define MIC_VECTOR_STEP   16'h0008

`endif

// *** include/mic_pkg.sv ***
package mic_pkg;

  // Request inputs from pins and peripherals
  typedef struct packed {
    logic       ext0_n;
    logic       ext1_n;
    logic       timer0_ovf;
    logic       timer1_ovf;
    logic       serial0_rx;
    logic       serial0_tx;
    logic       ext2;
    logic       ext3;
    logic [3:0] ext4;
    logic [3:0] ext5;
    logic [3:0] ext6;
  } mic_src_t;

  // Forced call presented to the instruction sequencer
  typedef struct packed {
    logic        long_call;
    logic [15:0] vector;
    logic [1:0]  level;
  } mic_call_t;

  typedef enum logic [0:0] {
    MIC_ST_IDLE = 1'b0,
    MIC_ST_CALL = 1'b1
  } mic_state_t;

endpackage

// *** hdl/mic_top.sv ***
`timescale 1ns/1ps
`include "mic_regs.svh"
module mic_top #(
  parameter int NSRC = 10,
  parameter int NLVL = 4
) (
  input  wire logic               clk_i,
  input  wire logic               reset_n_i,
  input  wire mic_pkg::mic_src_t  src_i,
  input  wire logic               mcycle_i,
  input  wire logic               insn_boundary_i,
  input  wire logic               return_from_interrupt_i,
  output mic_pkg::mic_call_t      call_o,
  output logic                    irq_o,
  input  wire logic [7:0]         s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [7:0]         s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready
);
  import mic_pkg::*;

  // ----------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------
  // Byte-lane merge for partial writes
  function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [15:0] vector_of(input logic [3:0] idx);
    return `MIC_VECTOR_BASE + 16'(idx) * `MIC_VECTOR_STEP;
  endfunction

  // ----------------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------------
  logic [7:0]        interrupt_enable_first;
  logic [7:0]        interrupt_enable_second;
  logic [3:0]        trig;
  logic [2*NSRC-1:0] prio;
  logic [NSRC-1:0]   flags;
  logic [NSRC-1:0]   mask;
  logic [NLVL-1:0]   in_service;
  mic_state_t        state;
  logic [2:0]        call_cnt;
  logic [3:0]        last_src;
  mic_src_t          src_d;
  // Bus handshake state
  logic              aw_held;
  logic              w_held;
  logic [7:0]        aw_addr;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;
  logic              wr_fire;
  logic              wr_hit;
  // Event decode
  logic [NSRC-1:0]   ev_set;
  logic [NSRC-1:0]   lvl_clr;
  logic [NSRC-1:0]   sw_clr;
  logic [NSRC-1:0]   svc_clr;
  logic [NSRC-1:0]   src_en;
  logic [NSRC-1:0]   pend;
  logic              win_found;
  logic [3:0]        win_idx;
  logic [1:0]        win_lvl;
  logic [2:0]        cur_rank;
  logic              take;

  // ----------------------------------------------------------------------
  // Request decode
  // ----------------------------------------------------------------------
  // Previous input levels for edge detection
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      src_d <= '{ext0_n: 1'b1, ext1_n: 1'b1, default: '0};
    end else begin
      src_d <= src_i;
    end
  end
  // Flag set terms; level-mode externals mirror the pin
  always_comb begin
    ev_set  = '0;
    lvl_clr = '0;
    ev_set[0] = trig[`MIC_TRIG_IT0_BIT] ? (src_d.ext0_n & ~src_i.ext0_n)
                                        : ~src_i.ext0_n;
    lvl_clr[0] = ~trig[`MIC_TRIG_IT0_BIT] & src_i.ext0_n;
    ev_set[1] = src_i.timer0_ovf;
    ev_set[2] = trig[`MIC_TRIG_IT1_BIT] ? (src_d.ext1_n & ~src_i.ext1_n)
                                        : ~src_i.ext1_n;
    lvl_clr[2] = ~trig[`MIC_TRIG_IT1_BIT] & src_i.ext1_n;
    ev_set[3] = src_i.timer1_ovf;
    ev_set[4] = src_i.serial0_rx | src_i.serial0_tx;
    ev_set[5] = trig[`MIC_TRIG_X2_BIT] ? (~src_d.ext2 & src_i.ext2)
                                       : (src_d.ext2 & ~src_i.ext2);
    ev_set[6] = trig[`MIC_TRIG_X3_BIT] ? (~src_d.ext3 & src_i.ext3)
                                       : (src_d.ext3 & ~src_i.ext3);
    // Peripheral groups are OR'ed, then made rising-edge events
    ev_set[7] = ~(|src_d.ext4) & (|src_i.ext4);
    ev_set[8] = ~(|src_d.ext5) & (|src_i.ext5);
    ev_set[9] = ~(|src_d.ext6) & (|src_i.ext6);
  end
  // Per-source enables; bit 6 of the first register is kept but unused
  assign src_en = {interrupt_enable_second[5:1], interrupt_enable_first[4:0]};
  assign pend   = flags & src_en & {NSRC{interrupt_enable_first[`MIC_IEN_GLOBAL_BIT]}};

  // ----------------------------------------------------------------------
  // Arbitration
  // ----------------------------------------------------------------------
  // Rank 0 means idle, otherwise highest active level plus one
  always_comb begin
    cur_rank = 3'd0;
    for (int l = 0; l < NLVL; l++) begin
      if (in_service[l]) begin
        cur_rank = 3'(l + 1);
      end
    end
  end
  // Highest level first; lowest source index breaks a tie
  always_comb begin
    win_found = 1'b0;
    win_idx   = 4'h0;
    win_lvl   = 2'd0;
    for (int l = NLVL - 1; l >= 0; l--) begin
      for (int s = 0; s < NSRC; s++) begin
        if (!win_found && pend[s] && prio[2*s +: 2] == 2'(l)
            && 3'(l + 1) > cur_rank) begin
          win_found = 1'b1;
          win_idx   = 4'(s);
          win_lvl   = 2'(l);
        end
      end
    end
  end
  // Poll once per machine cycle, only at an instruction boundary
  assign take = (state == MIC_ST_IDLE) && mcycle_i && insn_boundary_i
                && win_found;

  // ----------------------------------------------------------------------
  // Forced call sequencer
  // ----------------------------------------------------------------------
  // One detect cycle plus six for the long call gives seven minimum
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state    <= MIC_ST_IDLE;
      call_cnt <= 3'd0;
      call_o   <= '0;
      last_src <= 4'h0;
    end else begin
      unique case (state)
        MIC_ST_IDLE: begin
          if (take) begin
            state          <= MIC_ST_CALL;
            call_cnt       <= `MIC_LONG_CALL_MCYCLES;
            call_o.long_call <= 1'b1;
            call_o.vector  <= vector_of(win_idx);
            call_o.level   <= win_lvl;
            last_src       <= win_idx;
          end
        end
        MIC_ST_CALL: begin
          if (mcycle_i) begin
            if (call_cnt == 3'd1) begin
              state            <= MIC_ST_IDLE;
              call_o.long_call <= 1'b0;
            end
            call_cnt <= call_cnt - 3'd1;
          end
        end
      endcase
    end
  end
  // Service level stack; return drops the highest active level
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      in_service <= '0;
    end else if (take) begin
      in_service[win_lvl] <= 1'b1;
    end else if (return_from_interrupt_i && state == MIC_ST_IDLE && cur_rank != 3'd0) begin
      in_service[2'(cur_rank - 3'd1)] <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Request flags (sticky except level-mode externals, which follow the pin; write one to clear)
  // ----------------------------------------------------------------------
  assign svc_clr = take ? (NSRC'(1) << win_idx) : '0;
  assign wr_hit  = wr_fire && aw_addr == `MIC_OFF_FLAGS;
  assign sw_clr  = (wr_hit && w_strb[0]) ? w_data[NSRC-1:0] : '0;
  // Second lane clears the upper flags
  logic [NSRC-1:0] sw_clr_hi;
  assign sw_clr_hi = (wr_hit && w_strb[1]) ? {w_data[NSRC-1:8], 8'h00} : '0;
  // Set wins over any clear in the same cycle, enable or not
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      flags <= '0;
    end else begin
      flags <= (flags & ~svc_clr & ~lvl_clr & ~{sw_clr_hi[NSRC-1:8], sw_clr[7:0]})
               | ev_set;
    end
  end
  assign irq_o = |(flags & mask);

  // ----------------------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------------------
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign wr_fire       = aw_held && w_held && !s_axi_bvalid;

  // Address and data may come in either order
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= 8'h00;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        unique case (aw_addr)
          `MIC_OFF_IEN_FIRST, `MIC_OFF_IEN_SECOND, `MIC_OFF_TRIG,
          `MIC_OFF_PRIO, `MIC_OFF_FLAGS, `MIC_OFF_MASK,
          `MIC_OFF_SVC: s_axi_bresp <= 2'b00;
          default:      s_axi_bresp <= 2'b10;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  // Control registers; SVC is read-only and silently ignores writes
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      interrupt_enable_first  <= `MIC_RST_IEN;
      interrupt_enable_second <= `MIC_RST_IEN;
      trig                    <= `MIC_RST_TRIG;
      prio                    <= `MIC_RST_PRIO;
      mask                    <= `MIC_RST_MASK;
    end else if (wr_fire) begin
      unique case (aw_addr)
        `MIC_OFF_IEN_FIRST: interrupt_enable_first <= 8'(merge_strb(
            32'(interrupt_enable_first), w_data, w_strb)) & `MIC_IEN_FIRST_WMASK;
        `MIC_OFF_IEN_SECOND: interrupt_enable_second <= 8'(merge_strb(
            32'(interrupt_enable_second), w_data, w_strb)) & `MIC_IEN_SECOND_WMASK;
        `MIC_OFF_TRIG: trig <= 4'(merge_strb(32'(trig), w_data, w_strb));
        `MIC_OFF_PRIO: prio <= 20'(merge_strb(32'(prio), w_data, w_strb));
        `MIC_OFF_MASK: mask <= 10'(merge_strb(32'(mask), w_data, w_strb));
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------------
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= 2'b00;
      unique case ({s_axi_araddr[7:2], 2'b00})
        `MIC_OFF_IEN_FIRST:  s_axi_rdata <= 32'(interrupt_enable_first);
        `MIC_OFF_IEN_SECOND: s_axi_rdata <= 32'(interrupt_enable_second);
        `MIC_OFF_TRIG:       s_axi_rdata <= 32'(trig);
        `MIC_OFF_PRIO:       s_axi_rdata <= 32'(prio);
        `MIC_OFF_FLAGS:      s_axi_rdata <= 32'(flags);
        `MIC_OFF_MASK:       s_axi_rdata <= 32'(mask);
        `MIC_OFF_SVC: s_axi_rdata <= {call_o.vector, 4'h0, last_src,
                                      3'b000, call_o.long_call, in_service};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= 2'b10;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// *** bench/mic_top_sva.sv ***
`timescale 1ns/1ps
module mic_top_chk (
  input wire logic               clk_i,
  input wire logic               reset_n_i,
  input wire logic               mcycle_i,
  input wire logic               insn_boundary_i,
  input wire mic_pkg::mic_call_t call_o,
  input wire logic               s_axi_awready,
  input wire logic               s_axi_wready,
  input wire logic               s_axi_arvalid,
  input wire logic               s_axi_arready,
  input wire logic               s_axi_bvalid,
  input wire logic               s_axi_bready,
  input wire logic [1:0]         s_axi_bresp,
  input wire logic               s_axi_rvalid,
  input wire logic               s_axi_rready,
  input wire logic [31:0]        s_axi_rdata
);
  import mic_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  logic [2:0] mc_cnt;
  // Machine cycles seen inside a forced call; cleared between calls
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) mc_cnt <= 3'h0;
    else if (!call_o.long_call) mc_cnt <= 3'h0;
    else if (mcycle_i) mc_cnt <= mc_cnt + 3'h1;
  end
  // ----------------------------------------------------------------------
  // Forced call
  // ----------------------------------------------------------------------
  chk_vec_table: assert property ($rose(call_o.long_call) |->
    call_o.vector[2:0] == 3'h3 && call_o.vector <= 16'h004b) else $error("vector off table");
  chk_poll_edge: assert property ($rose(call_o.long_call) |->
    $past(mcycle_i && insn_boundary_i)) else $error("call not at a poll");
  chk_call_len: assert property ($fell(call_o.long_call) |-> mc_cnt == 3'h6)
    else $error("call length wrong");
  chk_call_max: assert property (call_o.long_call |-> mc_cnt < 3'h6)
    else $error("call too long");
  chk_vec_hold: assert property (!$rose(call_o.long_call) |->
    $stable(call_o.vector) && $stable(call_o.level)) else $error("vector moved");
  // ----------------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------------
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
  chk_r_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answering");
endmodule
bind mic_top mic_top_chk u_mic_top_chk (.clk_i, .reset_n_i, .mcycle_i, .insn_boundary_i,
  .call_o, .s_axi_awready, .s_axi_wready, .s_axi_arvalid, .s_axi_arready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_bresp, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata);

// *** bench/mic_core_model.sv ***
`timescale 1ns/1ps
module mic_core_model (
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  input  wire logic return_from_interrupt_req_i,
  output logic      mcycle_o,
  output logic      insn_boundary_o,
  output logic      return_from_interrupt_o
);
  logic [1:0] div;
  // One machine cycle every three clocks
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      div      <= 2'h0;
      mcycle_o <= 1'b0;
    end else begin
      div      <= (div == 2'h2) ? 2'h0 : div + 2'h1;
      mcycle_o <= (div == 2'h2);
    end
  end
  // Two-cycle instructions, so half the polls are not boundaries
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) insn_boundary_o <= 1'b0;
    else if (mcycle_o) insn_boundary_o <= ~insn_boundary_o;
  end
  // Return executes one clock after it is asked for
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) return_from_interrupt_o <= 1'b0;
    else return_from_interrupt_o <= return_from_interrupt_req_i;
  end
endmodule

// *** bench/test_mpu_interrupt_controller.sv ***
`timescale 1ns/1ps
module test_mpu_interrupt_controller;
  import mic_pkg::*;
  typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] e;} mic_row_t;
  localparam mic_src_t IDLE = '{ext0_n: 1'b1, ext1_n: 1'b1, default: '0};
  logic clk_i, reset_n_i, mcycle_i, insn_boundary_i, return_from_interrupt_i, return_from_interrupt_req, irq_o, saw_call;
  mic_src_t src_i;
  mic_call_t call_o;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int fail_count = 0;
  int cmp_count = 0;
  // Writable bits, read back through the bus
  mic_row_t rows[6] = '{'{8'ha8, 32'hff, 32'hdf}, '{8'hb8, 32'hff, 32'h7e},
    '{8'hb0, 32'hf, 32'hf}, '{8'hb4, 32'hfffff, 32'hfffff}, '{8'hc0, 32'h3ff, 32'h3ff},
    '{8'ha8, 32'h0, 32'h0}};
  mic_top u_mic_top (.clk_i, .reset_n_i, .src_i, .mcycle_i, .insn_boundary_i, .return_from_interrupt_i,
    .call_o, .irq_o, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  mic_core_model u_mic_core_model (.clk_i, .reset_n_i, .return_from_interrupt_req_i(return_from_interrupt_req),
    .mcycle_o(mcycle_i), .insn_boundary_o(insn_boundary_i), .return_from_interrupt_o(return_from_interrupt_i));
  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task test_done;
    if (fail_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Answer ready is offered up front; only the watchdog ends a wait
  task wr(input logic [7:0] a, input logic [31:0] w);
    @(posedge clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= w;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task wcall(input logic [15:0] v, input logic [1:0] lv);
    while (!call_o.long_call) @(posedge clk_i);
    chk("vector", {16'h0, call_o.vector}, {16'h0, v});
    chk("level", {30'h0, call_o.level}, {30'h0, lv});
    while (call_o.long_call) @(posedge clk_i);
  endtask
  task quiet;
    saw_call <= 1'b0;
    repeat (60) @(posedge clk_i);
    chk("no call", {31'h0, saw_call}, 32'h0);
  endtask
  task ret;
    @(posedge clk_i);
    return_from_interrupt_req <= 1'b1;
    @(posedge clk_i);
    return_from_interrupt_req <= 1'b0;
  endtask
  always @(posedge clk_i) if (call_o.long_call) saw_call <= 1'b1;
  initial begin clk_i = 1'b0; forever #25 clk_i = ~clk_i; end
  initial begin repeat (20000) @(posedge clk_i); fail_count++; test_done(); end
  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    reset_n_i = 1'b0;
    src_i = IDLE;
    return_from_interrupt_req = 1'b0;
    saw_call = 1'b0;
    s_axi_wstrb = 4'hf;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    repeat (3) @(posedge clk_i);
    reset_n_i <= 1'b1;
    rd(8'ha8);
    chk("enable reset", d, 32'h0);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a);
      chk("reg", d, rows[i].e);
    end
    rd(8'h10);
    chk("unmapped rresp", {30'h0, r}, 32'h2);
    wr(8'h10, 32'h1);
    chk("unmapped bresp", {30'h0, r}, 32'h2);
    wr(8'hb4, 32'h0);
    wr(8'hc0, 32'h0);
    wr(8'hb8, 32'h0);
    // Flag and interrupt output with every enable off
    @(posedge clk_i);
    src_i.timer0_ovf <= 1'b1;
    @(posedge clk_i);
    src_i <= IDLE;
    rd(8'hbc);
    chk("flag set", d, 32'h2);
    wr(8'hc0, 32'h2);
    chk("irq", {31'h0, irq_o}, 32'h1);
    wr(8'hc0, 32'h0);
    chk("irq masked", {31'h0, irq_o}, 32'h0);
    wr(8'hc0, 32'h2);
    wr(8'hbc, 32'h2);
    chk("irq cleared", {31'h0, irq_o}, 32'h0);
    wr(8'hc0, 32'h0);
    // Two flags at one level, global enable still off
    wr(8'ha8, 32'h1a);
    @(posedge clk_i);
    src_i.timer0_ovf <= 1'b1;
    src_i.timer1_ovf <= 1'b1;
    @(posedge clk_i);
    src_i <= IDLE;
    quiet();
    wr(8'ha8, 32'h9a);
    wcall(16'h000b, 2'd0);
    quiet();
    wr(8'hb4, 32'h300);
    @(posedge clk_i);
    src_i.serial0_rx <= 1'b1;
    @(posedge clk_i);
    src_i <= IDLE;
    wcall(16'h0023, 2'd3);
    rd(8'hc4);
    chk("service state", d, 32'h0023_0409);
    ret();
    quiet();
    ret();
    wcall(16'h001b, 2'd0);
    ret();
    rd(8'hbc);
    chk("flags auto cleared", d, 32'h0);
    // Trigger types on a held low pin, every enable off
    wr(8'ha8, 32'h0);
    @(posedge clk_i);
    src_i.ext0_n <= 1'b0;
    repeat (2) @(posedge clk_i);
    rd(8'hbc);
    chk("edge flag", d, 32'h1);
    wr(8'hbc, 32'h1);
    rd(8'hbc);
    chk("edge no repeat", d, 32'h0);
    wr(8'hb0, 32'he);
    rd(8'hbc);
    chk("level flag", d, 32'h1);
    wr(8'hbc, 32'h1);
    rd(8'hbc);
    chk("level beats clear", d, 32'h1);
    @(posedge clk_i);
    src_i <= IDLE;
    repeat (2) @(posedge clk_i);
    rd(8'hbc);
    chk("level released", d, 32'h0);
    // Shared and grouped requesters, upper lane clear
    @(posedge clk_i);
    src_i.serial0_tx <= 1'b1;
    src_i.ext2 <= 1'b1;
    src_i.ext4 <= 4'h4;
    src_i.ext5 <= 4'h1;
    src_i.ext6 <= 4'h8;
    @(posedge clk_i);
    src_i <= IDLE;
    rd(8'hbc);
    chk("shared flags", d, 32'h3b0);
    wr(8'hbc, 32'h3ff);
    rd(8'hbc);
    chk("shared cleared", d, 32'h0);
    // Reset in mid-run returns every register to zero
    wr(8'hc0, 32'h3ff);
    @(posedge clk_i);
    src_i.timer1_ovf <= 1'b1;
    @(posedge clk_i);
    src_i <= IDLE;
    @(negedge clk_i);
    chk("irq before reset", {31'h0, irq_o}, 32'h1);
    @(posedge clk_i);
    reset_n_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk("irq in reset", {31'h0, irq_o}, 32'h0);
    reset_n_i <= 1'b1;
    rd(8'hc0);
    chk("mask after reset", d, 32'h0);
    rd(8'hb0);
    chk("trig after reset", d, 32'h0);
    rd(8'hbc);
    chk("flags after reset", d, 32'h0);
    rd(8'hc4);
    chk("service after reset", d, 32'h0);
    test_done();
  end
endmodule
